// ---- src/ssc_exec.sv ----
`timescale 1ns/10ps
module ssc_exec import ssc_pkg::*; (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic INSTR_VALID_I,
    input wire logic [15:0] INSTR_I,
    output logic INSTR_READY_O,
    input wire logic [31:0] STATUS_WORD_I,
    input wire logic [31:0] GLOBAL_BASE_POINTER_I,
    input wire logic [31:0] VECTOR_BASE_POINTER_I,
    input wire logic [31:0] SAVED_STATUS_COPY_I,
    input wire logic [31:0] SAVED_PROGRAM_COUNTER_I,
    input wire logic [31:0] SAVED_STACK_POINTER_I,
    input wire logic [31:0] DEBUG_BASE_POINTER_I,
    output logic [3:0] GPR_RADDR_O,
    input wire logic [31:0] GPR_RDATA_I,
    output logic [2:0] BANK_IDX_O,
    output logic BANK_SEL_O,
    input wire logic [31:0] BANK_RDATA_I,
    output logic GPR_WE_O,
    output logic [3:0] GPR_WADDR_O,
    output logic [31:0] GPR_WDATA_O,
    output logic MEM_WE_O,
    output logic [31:0] MEM_ADDR_O,
    output logic [31:0] MEM_WDATA_O,
    output logic [3:0] PC_STEP_O,
    output logic ILLEGAL_O,
    output logic SLEEP_O,
    output logic [7:0] STANDBY_MODE_O,
    input wire logic IRQ_REQ_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic IRQ_O
);
    typedef struct packed {
        logic [2:0] kind;
        logic [1:0] cnt;
        logic priv;
    } ssc_dec_t;

    typedef struct packed {
        ssc_state_t st;
        logic [1:0] cnt;
        logic [15:0] ir;
        logic [7:0] stby;
        logic [1:0] irq_sync;
        logic gpr_we;
        logic [3:0] gpr_waddr;
        logic [31:0] gpr_wdata;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic [3:0] pc_step;
        logic illegal;
        logic [31:0] prdata;
        logic pslverr;
    } ssc_st_t;

    ssc_st_t r;
    ssc_st_t next_r;
    ssc_irq_if irq_bus();

    ssc_irq u_irq (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .bus(irq_bus)
    );

    // ==========================================================
    // special codes, group and low byte both matter
    function automatic logic is_sgr(input logic [15:0] ir);
        return (ir[15:12] == GRP_STC_REG && ir[7:0] == LO_SGR_REG) ||
               (ir[15:12] == GRP_MEM && ir[7:0] == LO_SGR_MEM);
    endfunction

    function automatic logic is_dbr(input logic [15:0] ir);
        return (ir[15:12] == GRP_STC_REG && ir[7:0] == LO_DBR_REG) ||
               (ir[15:12] == GRP_MEM && ir[7:0] == LO_DBR_MEM);
    endfunction

    // ==========================================================
    // instruction decode
    function automatic ssc_dec_t decode(input logic [15:0] ir);
        ssc_dec_t d;
        d = '{kind: OP_NONE, cnt: CNT_STC, priv: 1'b1};
        if (ir == OPC_SLEEP) begin
            d.kind = OP_SLEEP;
            d.cnt = CNT_SLEEP;
        end else if (ir[15:12] == GRP_MEM && (ir[7:0] == LO_SHR2 ||
                     ir[7:0] == LO_SHR8 || ir[7:0] == LO_SHR16)) begin
            d.kind = OP_SHR;
            d.cnt = CNT_SHIFT;
            d.priv = 1'b0;
        end else if (ir[15:12] == GRP_STC_REG && (ir[7:0] == LO_SGR_REG ||
                     ir[7:0] == LO_DBR_REG)) begin
            d.kind = OP_STC_REG;
        end else if (ir[15:12] == GRP_STC_REG && ir[3:0] == NIB_STC_REG &&
                     (ir[7] || ir[6:4] <= SEL_SPC)) begin
            d.kind = OP_STC_REG;
        end else if (ir[15:12] == GRP_MEM && (ir[7:0] == LO_SGR_MEM ||
                     ir[7:0] == LO_DBR_MEM)) begin
            d.kind = OP_STC_MEM;
        end else if (ir[15:12] == GRP_MEM && ir[3:0] == NIB_STC_MEM &&
                     (ir[7] || ir[6:4] <= SEL_SPC)) begin
            d.kind = OP_STC_MEM;
        end
        if (d.kind == OP_STC_REG || d.kind == OP_STC_MEM) begin
            if (is_sgr(ir)) begin
                d.cnt = CNT_SGR;
            end
            if (ir[3:0] != NIB_STC_REG || ir[15:12] != GRP_MEM) begin
                if (ir[7:4] == {1'b0, SEL_GBR}) begin
                    d.priv = 1'b0;
                end
            end
        end
        return d;
    endfunction

    // ==========================================================
    // control register source select
    function automatic logic [31:0] ctrl_src(input logic [15:0] ir);
        logic [31:0] v;
        v = BANK_RDATA_I;
        if (is_sgr(ir)) begin
            v = SAVED_STACK_POINTER_I;
        end else if (is_dbr(ir)) begin
            v = DEBUG_BASE_POINTER_I;
        end else if (!ir[7]) begin
            unique case (ir[6:4])
                SEL_SR: v = STATUS_WORD_I;
                SEL_GBR: v = GLOBAL_BASE_POINTER_I;
                SEL_VBR: v = VECTOR_BASE_POINTER_I;
                SEL_SSR: v = SAVED_STATUS_COPY_I;
                default: v = SAVED_PROGRAM_COUNTER_I;
            endcase
        end
        return v;
    endfunction

    ssc_dec_t in_dec;
    ssc_dec_t ex_dec;
    logic user_mode;
    logic apb_wr;
    logic apb_setup;
    logic done;
    logic [2:0] events;

    assign in_dec = decode(INSTR_I);
    assign ex_dec = decode(r.ir);
    assign user_mode = ~STATUS_WORD_I[SR_MD_BIT];
    assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign done = (r.st == ST_EXEC) && (r.cnt == 2'h0);

    // ==========================================================
    // execution sequencer
    always_comb begin
        next_r = r;
        events = 3'h0;
        next_r.irq_sync = {r.irq_sync[0], IRQ_REQ_I};
        next_r.gpr_we = 1'b0;
        next_r.mem_we = 1'b0;
        next_r.pc_step = 4'h0;
        next_r.illegal = 1'b0;
        unique case (r.st)
            ST_IDLE: begin
                if (INSTR_VALID_I) begin
                    next_r.ir = INSTR_I;
                    if (in_dec.kind == OP_NONE || (in_dec.priv && user_mode)) begin
                        next_r.illegal = 1'b1;
                        events[EV_ILLEGAL] = 1'b1;
                    end else begin
                        next_r.st = ST_EXEC;
                        next_r.cnt = in_dec.cnt;
                    end
                end
            end
            ST_EXEC: begin
                next_r.cnt = r.cnt - 2'h1;
                if (done) begin
                    next_r.st = ST_IDLE;
                    next_r.pc_step = PC_STEP;
                    next_r.gpr_waddr = r.ir[11:8];
                    unique case (ex_dec.kind)
                        OP_SHR: begin
                            next_r.gpr_we = 1'b1;
                            unique case (r.ir[5:4])
                                2'b00: next_r.gpr_wdata = {2'h0, GPR_RDATA_I[31:2]};
                                2'b01: next_r.gpr_wdata = {8'h00, GPR_RDATA_I[31:8]};
                                default: next_r.gpr_wdata = {16'h0000, GPR_RDATA_I[31:16]};
                            endcase
                        end
                        OP_STC_REG: begin
                            next_r.gpr_we = 1'b1;
                            next_r.gpr_wdata = ctrl_src(r.ir);
                        end
                        OP_STC_MEM: begin
                            next_r.gpr_we = 1'b1;
                            next_r.gpr_wdata = GPR_RDATA_I - LONG_BYTES;
                            next_r.mem_we = 1'b1;
                            next_r.mem_addr = GPR_RDATA_I - LONG_BYTES;
                            next_r.mem_wdata = ctrl_src(r.ir);
                        end
                        default: begin
                            next_r.st = ST_SLEEP;
                            next_r.pc_step = 4'h0;
                            events[EV_SLEEP] = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                if (r.irq_sync[1]) begin
                    next_r.st = ST_IDLE;
                    events[EV_WAKE] = 1'b1;
                end
            end
        endcase
        // register bus
        next_r.pslverr = 1'b0;
        if (apb_setup) begin
            next_r.prdata = 32'h0000_0000;
            unique case (PADDR_I)
                REG_STBY_OFS: next_r.prdata = {24'h000000, r.stby};
                REG_IRQ_STAT_OFS: next_r.prdata = {29'h0, irq_bus.status};
                REG_IRQ_MASK_OFS: next_r.prdata = {29'h0, irq_bus.mask};
                REG_STATE_OFS: next_r.prdata = {28'h0, r.cnt, r.st};
                default: next_r.pslverr = 1'b1;
            endcase
        end else begin
            next_r.pslverr = r.pslverr;
        end
        if (apb_wr && PADDR_I == REG_STBY_OFS) begin
            next_r.stby = PWDATA_I[7:0];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            r <= '{st: ST_IDLE, cnt: 2'h0, ir: 16'h0000, stby: STBY_RESET,
                   irq_sync: 2'h0, gpr_we: 1'b0, gpr_waddr: 4'h0,
                   gpr_wdata: 32'h0000_0000, mem_we: 1'b0, mem_addr: 32'h0000_0000,
                   mem_wdata: 32'h0000_0000, pc_step: 4'h0, illegal: 1'b0,
                   prdata: 32'h0000_0000, pslverr: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // interrupt status connection
    assign irq_bus.events = events;
    assign irq_bus.clr = (apb_wr && PADDR_I == REG_IRQ_STAT_OFS) ? PWDATA_I[2:0] : 3'h0;
    assign irq_bus.mask_we = apb_wr && PADDR_I == REG_IRQ_MASK_OFS;
    assign irq_bus.mask_wdata = PWDATA_I[2:0];

    // ==========================================================
    // outputs
    assign INSTR_READY_O = (r.st == ST_IDLE);
    assign GPR_RADDR_O = r.ir[11:8];
    assign BANK_IDX_O = r.ir[6:4];
    assign BANK_SEL_O = ~STATUS_WORD_I[SR_RB_BIT];
    assign GPR_WE_O = r.gpr_we;
    assign GPR_WADDR_O = r.gpr_waddr;
    assign GPR_WDATA_O = r.gpr_wdata;
    assign MEM_WE_O = r.mem_we;
    assign MEM_ADDR_O = r.mem_addr;
    assign MEM_WDATA_O = r.mem_wdata;
    assign PC_STEP_O = r.pc_step;
    assign ILLEGAL_O = r.illegal;
    assign SLEEP_O = (r.st == ST_SLEEP);
    assign STANDBY_MODE_O = (r.st == ST_SLEEP) ? r.stby : 8'h00;
    assign PRDATA_O = r.prdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = r.pslverr;
    assign IRQ_O = irq_bus.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    logic take;
    assign take = INSTR_READY_O && INSTR_VALID_I;

    shr_two_a: assert property (done && ex_dec.kind == OP_SHR && r.ir[5:4] == 2'b00
        |=> GPR_WE_O && GPR_WDATA_O == {2'h0, $past(GPR_RDATA_I[31:2])})
        else $error("shift by two wrong");
    shr_time_a: assert property (take && in_dec.kind == OP_SHR && !user_mode
        |=> ##1 GPR_WE_O && PC_STEP_O == 4'h2)
        else $error("shift not done in one state");
    sleep_hold_a: assert property (SLEEP_O && !r.irq_sync[1] |=> SLEEP_O && !INSTR_READY_O)
        else $error("left power-down without request");
    sleep_wake_a: assert property (SLEEP_O && r.irq_sync[1] |=> INSTR_READY_O && !SLEEP_O)
        else $error("no wake on interrupt");
    sleep_user_a: assert property (take && INSTR_I == OPC_SLEEP && user_mode
        |=> ILLEGAL_O && INSTR_READY_O)
        else $error("user power-down not refused");
    sleep_time_a: assert property (take && INSTR_I == OPC_SLEEP && !user_mode
        |=> !SLEEP_O [*4] ##1 SLEEP_O && PC_STEP_O == 4'h0)
        else $error("power-down not four states");
    stc_push_a: assert property (done && ex_dec.kind == OP_STC_MEM
        |=> MEM_WE_O && MEM_ADDR_O == $past(GPR_RDATA_I) - 32'h4 && GPR_WDATA_O == MEM_ADDR_O)
        else $error("push address wrong");
    sgr_time_a: assert property (take && in_dec.kind == OP_STC_REG && !user_mode
        && INSTR_I[7:0] == LO_SGR_REG |=> !GPR_WE_O [*3] ##1 GPR_WE_O)
        else $error("saved stack pointer store not three states");
    ssr_source_a: assert property (done && ex_dec.kind == OP_STC_REG
        && r.ir[7:0] == {1'b0, SEL_SSR, NIB_STC_REG}
        |=> GPR_WDATA_O == $past(SAVED_STATUS_COPY_I))
        else $error("saved status store reads wrong source");
    gbr_user_a: assert property (take && user_mode && INSTR_I[15:12] == GRP_STC_REG
        && INSTR_I[7:0] == 8'h12 |=> !ILLEGAL_O)
        else $error("global base store refused");
    status_sticky_a: assert property (events[EV_ILLEGAL] |=> irq_bus.status[EV_ILLEGAL])
        else $error("illegal event not latched");

    cov_sleep_c: cover property (SLEEP_O ##1 !SLEEP_O);
    cov_push_c: cover property (MEM_WE_O);
    cov_bank_c: cover property (done && r.ir[7] && ex_dec.kind == OP_STC_REG);
    cov_irq_c: cover property (IRQ_O);
    cov_sgr_c: cover property (done && is_sgr(r.ir));
endmodule

// ---- src/ssc_pkg.sv ----
package ssc_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] REG_STBY_OFS = 8'h00;
    localparam logic [7:0] REG_IRQ_STAT_OFS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK_OFS = 8'h08;
    localparam logic [7:0] REG_STATE_OFS = 8'h0C;
    localparam logic [7:0] STBY_RESET = 8'h00;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    // ==========================================================
    // interrupt events
    localparam int NUM_EV = 3;
    localparam int EV_ILLEGAL = 0;
    localparam int EV_SLEEP = 1;
    localparam int EV_WAKE = 2;
    // ==========================================================
    // status word fields
    localparam int SR_MD_BIT = 30;
    localparam int SR_RB_BIT = 29;
    // ==========================================================
    // opcode fields
    localparam logic [3:0] GRP_STC_REG = 4'h0;
    localparam logic [3:0] GRP_MEM = 4'h4;
    localparam logic [15:0] OPC_SLEEP = 16'h001B;
    localparam logic [7:0] LO_SHR2 = 8'h09;
    localparam logic [7:0] LO_SHR8 = 8'h19;
    localparam logic [7:0] LO_SHR16 = 8'h29;
    localparam logic [7:0] LO_SGR_REG = 8'h3A;
    localparam logic [7:0] LO_DBR_REG = 8'hFA;
    localparam logic [7:0] LO_SGR_MEM = 8'h32;
    localparam logic [7:0] LO_DBR_MEM = 8'hF2;
    localparam logic [3:0] NIB_STC_REG = 4'h2;
    localparam logic [3:0] NIB_STC_MEM = 4'h3;
    localparam logic [2:0] SEL_SR = 3'h0;
    localparam logic [2:0] SEL_GBR = 3'h1;
    localparam logic [2:0] SEL_VBR = 3'h2;
    localparam logic [2:0] SEL_SSR = 3'h3;
    localparam logic [2:0] SEL_SPC = 3'h4;
    // ==========================================================
    // execution states and derived counts
    localparam int STATES_SHIFT = 1;
    localparam int STATES_SLEEP = 4;
    localparam int STATES_STC = 2;
    localparam int STATES_SGR = 3;
    localparam logic [1:0] CNT_SHIFT = 2'(STATES_SHIFT - 1);
    localparam logic [1:0] CNT_SLEEP = 2'(STATES_SLEEP - 1);
    localparam logic [1:0] CNT_STC = 2'(STATES_STC - 1);
    localparam logic [1:0] CNT_SGR = 2'(STATES_SGR - 1);
    localparam logic [31:0] LONG_BYTES = 32'h0000_0004;
    localparam logic [3:0] PC_STEP = 4'h2;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_SLEEP = 2'b10
    } ssc_state_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SHR = 3'b001,
        OP_SLEEP = 3'b010,
        OP_STC_REG = 3'b011,
        OP_STC_MEM = 3'b100
    } ssc_op_t;
endpackage

// ---- src/ssc_irq_if.sv ----
`timescale 1ns/10ps
interface ssc_irq_if;
    logic [2:0] events;
    logic [2:0] clr;
    logic mask_we;
    logic [2:0] mask_wdata;
    logic [2:0] status;
    logic [2:0] mask;
    logic irq;
    modport ctrl (output events, clr, mask_we, mask_wdata, input status, mask, irq);
    modport irq_side (input events, clr, mask_we, mask_wdata, output status, mask, irq);
endinterface

// ---- src/ssc_irq.sv ----
`timescale 1ns/10ps
module ssc_irq import ssc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    ssc_irq_if.irq_side bus
);
    typedef struct packed {
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] mask;
    } ssc_irq_st_t;
    ssc_irq_st_t r;
    ssc_irq_st_t next_r;

    // set wins over a write-one clear in the same cycle
    always_comb begin
        next_r = r;
        next_r.status = (r.status & ~bus.clr) | bus.events;
        if (bus.mask_we) begin
            next_r.mask = bus.mask_wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= {{NUM_EV{1'b0}}, IRQ_MASK_RESET};
        end else begin
            r <= next_r;
        end
    end

    assign bus.status = r.status;
    assign bus.mask = r.mask;
    assign bus.irq = |(r.status & r.mask);
endmodule

// ---- testbench/ssc_core_model.sv ----
`timescale 1ns/10ps
module ssc_core_model (
    input wire logic clk_i,
    input wire logic [3:0] raddr_i,
    output logic [31:0] rdata_o,
    input wire logic [2:0] bank_idx_i,
    input wire logic bank_sel_i,
    output logic [31:0] bank_rdata_o,
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [31:0] wdata_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i
);
    logic [31:0] gpr [16];
    logic [31:0] mem_addr;
    logic [31:0] mem_data;
    // ==========================================================
    // register file with combinational reads
    assign rdata_o = gpr[raddr_i];
    // banked value encodes bank and index so a wrong pick shows
    assign bank_rdata_o = {28'hBA00000, bank_sel_i, bank_idx_i};
    initial begin
        for (int i = 0; i < 16; i++) begin
            gpr[i] = (i < 4) ? 32'h12345678 : 32'h10000000 + 32'(i * 256);
        end
    end
    always @(posedge clk_i) begin
        if (we_i) begin
            gpr[waddr_i] <= wdata_i;
        end
        if (mem_we_i) begin
            mem_addr <= mem_addr_i;
            mem_data <= mem_wdata_i;
        end
    end
endmodule

// ---- testbench/shift_sleep_ctrlstore_exec_tb_top.sv ----
`timescale 1ns/10ps
module shift_sleep_ctrlstore_exec_tb_top import ssc_pkg::*;;
    logic clk, rst, vld, irq_req, psel, pen, pwr;
    logic [15:0] ins;
    logic [7:0] padr;
    logic [31:0] pwd, sw, rd;
    logic [31:0] ctl [1:6];
    logic ready, bsel, gwe, mwe, ill, slp, pready, perr, irq, err;
    logic [3:0] raddr, gwa, pcs;
    logic [2:0] bidx;
    logic [31:0] rdata, brdata, gwd, madr, mwd, prdata;
    logic [7:0] stby;
    logic c_we, c_mwe, c_ill;
    logic [3:0] c_wa, c_pc;
    logic [31:0] c_wd, c_ma, c_md, a, e;
    logic [7:0] lo [3];
    logic [31:0] shx [3];
    logic [15:0] op;
    int bad_count, n_compared, cyc, n;

    ssc_exec u_dut (.CORE_CLK_I(clk), .RESET_I(rst), .INSTR_VALID_I(vld), .INSTR_I(ins),
        .INSTR_READY_O(ready), .STATUS_WORD_I(sw), .GLOBAL_BASE_POINTER_I(ctl[1]),
        .VECTOR_BASE_POINTER_I(ctl[2]), .SAVED_STATUS_COPY_I(ctl[3]),
        .SAVED_PROGRAM_COUNTER_I(ctl[4]), .SAVED_STACK_POINTER_I(ctl[5]),
        .DEBUG_BASE_POINTER_I(ctl[6]), .GPR_RADDR_O(raddr), .GPR_RDATA_I(rdata),
        .BANK_IDX_O(bidx), .BANK_SEL_O(bsel), .BANK_RDATA_I(brdata), .GPR_WE_O(gwe),
        .GPR_WADDR_O(gwa), .GPR_WDATA_O(gwd), .MEM_WE_O(mwe), .MEM_ADDR_O(madr),
        .MEM_WDATA_O(mwd), .PC_STEP_O(pcs), .ILLEGAL_O(ill), .SLEEP_O(slp),
        .STANDBY_MODE_O(stby), .IRQ_REQ_I(irq_req), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(perr), .IRQ_O(irq));
    ssc_core_model u_model (.clk_i(clk), .raddr_i(raddr), .rdata_o(rdata),
        .bank_idx_i(bidx), .bank_sel_i(bsel), .bank_rdata_o(brdata), .we_i(gwe),
        .waddr_i(gwa), .wdata_i(gwd), .mem_we_i(mwe), .mem_addr_i(madr), .mem_wdata_i(mwd));

    initial begin
        clk = 1'b0;
        forever begin
            #20 clk = ~clk;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic give_up();
        bad_count++;
        complete_run();
    endtask

    // ==========================================================
    // apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        padr <= ad;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            give_up();
        end
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    // ==========================================================
    // one instruction; snapshot of the result cycle, cycles counted from take
    task automatic run(input logic [15:0] o);
        int k;
        vld <= 1'b1;
        ins <= o;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ready !== 1'b1 && k < 50);
        vld <= 1'b0;
        cyc = 0;
        #1;
        while (gwe !== 1'b1 && mwe !== 1'b1 && ill !== 1'b1 && slp !== 1'b1 && cyc < 50) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        if (k >= 50 || cyc >= 50) begin
            give_up();
        end
        {c_we, c_wa, c_wd, c_mwe, c_ma, c_md, c_pc, c_ill} =
            {gwe, gwa, gwd, mwe, madr, mwd, pcs, ill};
        @(posedge clk);
    endtask

    initial begin
        {vld, irq_req, psel, pen, pwr, ins, padr, pwd} = '0;
        bad_count = 0;
        n_compared = 0;
        sw = 32'h600000F0;
        for (int i = 1; i <= 6; i++) begin
            ctl[i] = 32'hC0DE0000 + 32'(i);
        end
        lo = '{LO_SHR2, LO_SHR8, LO_SHR16};
        shx = '{32'h048D159E, 32'h00123456, 32'h00001234};
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // shifts on three registers holding the same value
        for (int k = 0; k < 3; k++) begin
            run({GRP_MEM, 4'(k + 1), lo[k]});
            check(cyc, STATES_SHIFT);
            check(c_wa, 4'(k + 1));
            check(c_wd, shx[k]);
            check({c_mwe, c_pc}, 5'h02);
        end
        // register-destination stores, five basic selectors
        for (int s = 0; s < 5; s++) begin
            run({GRP_STC_REG, 4'h5, 1'b0, 3'(s), NIB_STC_REG});
            e = (s == 0) ? sw : ctl[s];
            check({c_we, c_wa, c_pc}, 9'h152);
            check(c_wd, e);
            check(cyc, STATES_STC);
        end
        run({GRP_STC_REG, 4'h6, LO_SGR_REG});
        check(cyc, STATES_SGR);
        check(c_wd, ctl[5]);
        run({GRP_STC_REG, 4'h6, LO_DBR_REG});
        check(cyc, STATES_STC);
        check(c_wd, ctl[6]);
        // a code outside the group is refused
        run(16'hFFFF);
        check({c_ill, c_we, c_mwe}, 3'b100);
        // banked registers under both flag values
        for (int b = 0; b < 2; b++) begin
            sw[SR_RB_BIT] <= ~b[0];
            for (int m = 0; m < 8; m++) begin
                run({GRP_STC_REG, 4'h7, 1'b1, 3'(m), NIB_STC_REG});
                check(c_wd, {28'hBA00000, b[0], 3'(m)});
            end
        end
        // memory pushes: five basic, saved stack, debug base, banked 7
        a = 32'h10000800;
        for (int i = 0; i < 8; i++) begin
            op = (i < 5) ? {GRP_MEM, 4'h8, 1'b0, 3'(i), NIB_STC_MEM} :
                 (i == 5) ? {GRP_MEM, 4'h8, LO_SGR_MEM} :
                 (i == 6) ? {GRP_MEM, 4'h8, LO_DBR_MEM} : {GRP_MEM, 4'h8, 8'hF3};
            e = (i == 0) ? sw : (i < 7) ? ctl[i] : {28'hBA00000, 1'b1, 3'h7};
            run(op);
            a = a - 32'h4;
            check({c_mwe, c_we, c_wa}, {2'b11, 4'h8});
            check(c_ma, a);
            check(c_md, e);
            check(c_wd, a);
            check(cyc, (i == 5) ? STATES_SGR : STATES_STC);
        end
        // user mode: privileged forms refused, global base allowed
        sw <= 32'h00000000;
        run({GRP_STC_REG, 4'h5, 1'b0, SEL_VBR, NIB_STC_REG});
        check({c_ill, c_we, c_mwe}, 3'b100);
        check(cyc, 0);
        run({GRP_MEM, 4'h9, 1'b1, 3'h2, NIB_STC_MEM});
        check({c_ill, c_we, c_mwe}, 3'b100);
        run({GRP_STC_REG, 4'h5, 1'b0, SEL_GBR, NIB_STC_REG});
        check(c_ill, 1'b0);
        check(c_wd, ctl[1]);
        run({GRP_MEM, 4'h9, 1'b0, SEL_GBR, NIB_STC_MEM});
        check(c_ill, 1'b0);
        check(c_md, ctl[1]);
        run(OPC_SLEEP);
        check({c_ill, slp}, 2'b10);
        // illegal events raise the masked interrupt
        apb(1'b0, REG_IRQ_STAT_OFS, '0);
        check(rd[2:0], 3'b001);
        check(irq, 1'b0);
        apb(1'b1, REG_IRQ_MASK_OFS, 32'h1);
        check(irq, 1'b1);
        apb(1'b0, REG_IRQ_MASK_OFS, '0);
        check(rd[2:0], 3'b001);
        apb(1'b1, REG_IRQ_STAT_OFS, 32'h1);
        check(irq, 1'b0);
        apb(1'b0, 8'h10, '0);
        check(err, 1'b1);
        check(rd, 32'h0);
        // power-down with a chosen standby setting, then wake
        sw <= 32'h40000000;
        apb(1'b1, REG_STBY_OFS, 32'h5A);
        apb(1'b0, REG_STBY_OFS, '0);
        check(rd[7:0], 8'h5A);
        run(OPC_SLEEP);
        check(cyc, STATES_SLEEP);
        check({c_pc, c_we, c_mwe}, 6'h00);
        repeat (10) @(posedge clk);
        #1;
        check({slp, ready, stby}, {2'b10, 8'h5A});
        @(posedge clk);
        irq_req <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (slp !== 1'b0 && n < 50);
        check(n, 3);
        check({ready, stby}, 9'h100);
        @(posedge clk);
        irq_req <= 1'b0;
        apb(1'b0, REG_IRQ_STAT_OFS, '0);
        check({rd[2:0], irq}, 4'b1100);
        complete_run();
    end
endmodule
